/* File: design/dbrc_pkg.sv */
// package: constants, types and decode helpers for the flow sequencer
package dbrc_pkg;
  localparam int ADDR_W     = 24;
  localparam int CNT_W      = 32;
  localparam int FLAG_W     = 4;
  localparam int COND_W     = 4;
  localparam int SLOT_W     = 2;

  // delay slots that still run after a delayed branch
  localparam logic [SLOT_W-1:0] SLOT_COUNT = 2'h3;

  localparam logic [ADDR_W-1:0] RESET_PC    = 24'h000000;
  localparam logic [ADDR_W-1:0] RESET_START = 24'h000000;
  localparam logic [ADDR_W-1:0] RESET_END   = 24'h000000;
  localparam logic [CNT_W-1:0]  RESET_COUNT = 32'h00000000;
  localparam logic [ADDR_W-1:0] ADDR_ONE    = 24'h000001;
  localparam logic [CNT_W-1:0]  CNT_ONE     = 32'h00000001;

  // flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;

  // condition codes
  localparam logic [COND_W-1:0] COND_U  = 4'h0;
  localparam logic [COND_W-1:0] COND_EQ = 4'h1;
  localparam logic [COND_W-1:0] COND_NE = 4'h2;
  localparam logic [COND_W-1:0] COND_LT = 4'h3;
  localparam logic [COND_W-1:0] COND_LE = 4'h4;
  localparam logic [COND_W-1:0] COND_GT = 4'h5;
  localparam logic [COND_W-1:0] COND_GE = 4'h6;
  localparam logic [COND_W-1:0] COND_LO = 4'h7;
  localparam logic [COND_W-1:0] COND_HS = 4'h8;
  localparam logic [COND_W-1:0] COND_V  = 4'h9;
  localparam logic [COND_W-1:0] COND_NV = 4'hA;

  typedef enum logic [7:0] {
    OP_NONE       = 8'h01,
    OP_BRANCH     = 8'h02,
    OP_DBRANCH    = 8'h04,
    OP_CALL       = 8'h08,
    OP_CALL_REG   = 8'h10,
    OP_RETURN     = 8'h20,
    OP_BLOCK_RPT  = 8'h40,
    OP_SINGLE_RPT = 8'h80
  } dbrc_op_type;

  typedef enum logic [1:0] {
    DB_IDLE = 2'h1,
    DB_SLOT = 2'h2
  } dbrc_db_type;

  typedef enum logic [2:0] {
    RPT_OFF    = 3'h1,
    RPT_BLOCK  = 3'h2,
    RPT_SINGLE = 3'h4
  } dbrc_rpt_type;

  function automatic logic cond_true(input logic [COND_W-1:0] cond,
                                     input logic [FLAG_W-1:0] f);
    logic lt;
    lt = f[FLAG_N] ^ f[FLAG_V];
    case (cond)
      COND_U:  cond_true = 1'b1;
      COND_EQ: cond_true = f[FLAG_Z];
      COND_NE: cond_true = !f[FLAG_Z];
      COND_LT: cond_true = lt;
      COND_LE: cond_true = lt | f[FLAG_Z];
      COND_GT: cond_true = !lt & !f[FLAG_Z];
      COND_GE: cond_true = !lt;
      COND_LO: cond_true = f[FLAG_C];
      COND_HS: cond_true = !f[FLAG_C];
      COND_V:  cond_true = f[FLAG_V];
      COND_NV: cond_true = !f[FLAG_V];
      default: cond_true = 1'b0;
    endcase
  endfunction
endpackage

/* File: design/dbrc_loop_if.sv */
// interface: loop register traffic between sequencer and loop unit
`timescale 1ns/10ps
interface dbrc_loop_if;
  import dbrc_pkg::*;
  logic [ADDR_W-1:0] pc;
  logic              step;
  logic              load_block;
  logic              load_single;
  logic [ADDR_W-1:0] new_start;
  logic [ADDR_W-1:0] new_end;
  logic [CNT_W-1:0]  new_count;
  logic              wr_start;
  logic              wr_end;
  logic              wr_count;
  logic [ADDR_W-1:0] wr_addr;
  logic [CNT_W-1:0]  wr_cnt;
  logic [ADDR_W-1:0] start_addr;
  logic [ADDR_W-1:0] end_addr;
  logic [CNT_W-1:0]  count;
  dbrc_rpt_type      mode;
  logic              wrap;

  modport ctrl (
    output pc, step, load_block, load_single, new_start, new_end,
    output new_count, wr_start, wr_end, wr_count, wr_addr, wr_cnt,
    input  start_addr, end_addr, count, mode, wrap
  );
  modport loop (
    input  pc, step, load_block, load_single, new_start, new_end,
    input  new_count, wr_start, wr_end, wr_count, wr_addr, wr_cnt,
    output start_addr, end_addr, count, mode, wrap
  );
endinterface

/* File: design/dbrc_loop_unit.sv */
// loop unit: start, end and count registers and the loop-end test
`timescale 1ns/10ps
module dbrc_loop_unit
  import dbrc_pkg::*;
(
  // clock, reset, enable
  input  wire logic     i_clk,
  input  wire logic     i_reset_n,
  input  wire logic     i_enable,
  // sequencer side
  dbrc_loop_if.loop     lp
);
  import dbrc_pkg::*;

  logic hit;

  // both repeat kinds share this one test
  assign hit = (lp.mode != RPT_OFF) && lp.step
               && (lp.pc == lp.end_addr); // [RQ9]
  assign lp.wrap = hit && (lp.count != RESET_COUNT); // [RQ14]

  // single register set; nesting is left to software
  always_ff @(posedge i_clk or negedge i_reset_n) begin // [RQ8]
    if (!i_reset_n) begin
      lp.start_addr <= RESET_START;
      lp.end_addr   <= RESET_END;
    end else if (i_enable) begin
      if (lp.load_block || lp.load_single) begin
        lp.start_addr <= lp.new_start; // [RQ5]
        lp.end_addr   <= lp.new_end;
      end else begin
        if (lp.wr_start) begin
          lp.start_addr <= lp.wr_addr;
        end
        if (lp.wr_end) begin
          lp.end_addr <= lp.wr_addr;
        end
      end
    end
  end

  // loop-end decrement beats a software write in the same cycle
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lp.count <= RESET_COUNT;
    end else if (i_enable) begin
      if (lp.load_single) begin
        lp.count <= lp.new_count; // [RQ12]
      end else if (hit) begin
        lp.count <= lp.count - CNT_ONE; // [RQ6] [RQ7]
      end else if (lp.wr_count) begin
        lp.count <= lp.wr_cnt; // [RQ5]
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lp.mode <= RPT_OFF;
    end else if (i_enable) begin
      if (lp.load_single) begin
        lp.mode <= RPT_SINGLE; // [RQ4]
      end else if (lp.load_block) begin
        lp.mode <= RPT_BLOCK; // [RQ4]
      end else if (hit && !lp.wrap) begin
        lp.mode <= RPT_OFF; // [RQ14]
      end
    end
  end
endmodule

/* File: design/delayed_branch_repeat_ctrl.sv */
// top: program-flow sequencer with delayed branches and repeat loops
//
// Contract
// [RQ1] three slot instructions run before delayed transfer
// [RQ2] no flow-changing instruction inside delay slots
// [RQ3] delayed condition uses flags before the branch
// [RQ4] block and single repeat share loop registers
// [RQ5] repeat loads start/end; software loads count
// [RQ6] count N at entry gives N+1 passes
// [RQ7] loop-end instruction must not touch count/pc
// [RQ8] one register set; software saves for nesting
// [RQ9] single repeat uses same registers and termination
// [RQ10] single repeat fetches its instruction only once
// [RQ11] single repeat blocks interrupts; block repeat allows
// [RQ12] single repeat count comes from instruction operand
// [RQ13] register-mode call targets the register contents
// [RQ14] at loop end decrement, wrap while non-negative
`timescale 1ns/10ps
module delayed_branch_repeat_ctrl
  import dbrc_pkg::*;
(
  // clock, reset, enable
  input  wire logic                       i_clk,
  input  wire logic                       i_reset_n,
  input  wire logic                       i_enable,
  // issued instruction from decode
  input  wire logic                       i_issue,
  input  wire dbrc_pkg::dbrc_op_type      i_op,
  input  wire logic [dbrc_pkg::COND_W-1:0] i_cond,
  input  wire logic [dbrc_pkg::ADDR_W-1:0] i_target,
  input  wire logic [dbrc_pkg::ADDR_W-1:0] i_reg_value,
  input  wire logic [dbrc_pkg::CNT_W-1:0]  i_count_imm,
  input  wire logic [dbrc_pkg::FLAG_W-1:0] i_flags,
  // software moves into loop registers
  input  wire logic                       i_wr_start,
  input  wire logic                       i_wr_end,
  input  wire logic                       i_wr_count,
  input  wire logic [dbrc_pkg::ADDR_W-1:0] i_wr_addr,
  input  wire logic [dbrc_pkg::CNT_W-1:0]  i_wr_cnt,
  // interrupt accept path
  input  wire logic                       i_int_req,
  input  wire logic [dbrc_pkg::ADDR_W-1:0] i_int_vec,
  output logic                            o_int_ack,
  output logic                            o_int_hold,
  // fetch side
  output logic [dbrc_pkg::ADDR_W-1:0]      o_pc,
  output logic                            o_fetch_en,
  output logic                            o_reuse_instr,
  // call / return stack side
  output logic                            o_push,
  output logic [dbrc_pkg::ADDR_W-1:0]      o_ret_addr,
  // loop register view for save and restore
  output logic [dbrc_pkg::ADDR_W-1:0]      o_loop_start,
  output logic [dbrc_pkg::ADDR_W-1:0]      o_loop_end,
  output logic [dbrc_pkg::CNT_W-1:0]       o_loop_count,
  output logic                            o_loop_active,
  output logic                            o_slot_busy
);
  import dbrc_pkg::*;

  dbrc_loop_if lpif ();

  logic [ADDR_W-1:0] pc;
  logic [ADDR_W-1:0] next_pc;
  logic [ADDR_W-1:0] pc_inc;
  dbrc_db_type       db_state;
  logic [SLOT_W-1:0] slots_left;
  logic [ADDR_W-1:0] db_target;
  logic              db_taken;
  logic              single_fetched;
  logic              issue;
  logic              cond_ok;
  logic              int_allowed;
  logic              in_slots;
  logic              db_fire;
  logic              start_db;
  logic              take_call;
  logic [ADDR_W-1:0] call_target;

  dbrc_loop_unit u_loop (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_enable  (i_enable),
    .lp        (lpif.loop)
  );

  assign pc_inc  = pc + ADDR_ONE;
  assign in_slots = (db_state == DB_SLOT);
  // flags at issue are those left by the instruction before
  assign cond_ok = cond_true(i_cond, i_flags); // [RQ3]

  // interrupts wait out a single repeat and the delay slots
  assign int_allowed = (lpif.mode != RPT_SINGLE) && !in_slots; // [RQ11]
  assign o_int_ack   = i_enable && i_int_req && int_allowed;
  assign o_int_hold  = (lpif.mode == RPT_SINGLE); // [RQ11]
  assign issue       = i_enable && i_issue && !o_int_ack;

  // third slot completing hands control to the stored target
  assign db_fire = issue && in_slots && (slots_left == 2'h1); // [RQ1]
  assign start_db = issue && !in_slots && (i_op == OP_DBRANCH);

  // slot instructions are assumed flow-neutral, so ops there are ignored
  always_comb begin
    take_call   = 1'b0;
    call_target = i_target;
    if (issue && !in_slots && cond_ok) begin // [RQ2]
      case (i_op)
        OP_CALL: begin
          take_call = 1'b1;
        end
        OP_CALL_REG: begin
          take_call   = 1'b1;
          call_target = i_reg_value; // [RQ13]
        end
        default: begin
          take_call = 1'b0;
        end
      endcase
    end
  end

  // next program counter
  always_comb begin
    next_pc = pc;
    if (o_int_ack) begin
      next_pc = i_int_vec; // [RQ11]
    end else if (issue) begin
      next_pc = pc_inc;
      if (db_fire && db_taken) begin
        next_pc = db_target; // [RQ1]
      end else if (lpif.wrap) begin
        next_pc = lpif.start_addr; // [RQ14]
      end else if (!in_slots) begin
        case (i_op)
          OP_BRANCH: begin
            if (cond_ok) begin
              next_pc = i_target;
            end
          end
          OP_RETURN: begin
            if (cond_ok) begin
              next_pc = i_target;
            end
          end
          OP_CALL, OP_CALL_REG: begin
            if (take_call) begin
              next_pc = call_target;
            end
          end
          default: begin
            next_pc = pc_inc;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pc <= RESET_PC;
    end else if (i_enable) begin
      pc <= next_pc;
    end
  end

  // delayed branch slot tracking; no pipeline flush is needed
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      db_state   <= DB_IDLE;
      slots_left <= '0;
      db_target  <= RESET_PC;
      db_taken   <= 1'b0;
    end else if (i_enable) begin
      case (db_state)
        DB_IDLE: begin
          if (start_db) begin
            db_state   <= DB_SLOT; // [RQ1]
            slots_left <= SLOT_COUNT;
            db_target  <= i_target;
            db_taken   <= cond_ok; // [RQ3]
          end
        end
        DB_SLOT: begin
          if (issue) begin
            slots_left <= slots_left - 2'h1; // [RQ1]
            if (slots_left == 2'h1) begin
              db_state <= DB_IDLE;
            end
          end
        end
        default: begin
          db_state <= DB_IDLE;
        end
      endcase
    end
  end

  // single repeat: the held instruction is replayed, not refetched
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      single_fetched <= 1'b0;
    end else if (i_enable) begin
      if (lpif.mode != RPT_SINGLE) begin
        single_fetched <= 1'b0;
      end else if (issue && (pc == lpif.end_addr)) begin
        single_fetched <= lpif.wrap; // [RQ10]
      end
    end
  end

  assign o_fetch_en    = !single_fetched; // [RQ10]
  assign o_reuse_instr = single_fetched; // [RQ10]

  // return address for calls and accepted interrupts
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_push     <= 1'b0;
      o_ret_addr <= RESET_PC;
    end else if (i_enable) begin
      o_push <= o_int_ack || take_call;
      if (o_int_ack) begin
        o_ret_addr <= pc;
      end else if (take_call) begin
        o_ret_addr <= pc_inc;
      end
    end
  end

  // repeat instructions load the loop bounds themselves
  always_comb begin
    lpif.pc          = pc;
    lpif.step        = issue;
    lpif.load_block  = issue && !in_slots
                       && (i_op == OP_BLOCK_RPT); // [RQ4] [RQ5]
    lpif.load_single = issue && !in_slots
                       && (i_op == OP_SINGLE_RPT); // [RQ4] [RQ12]
    lpif.new_start   = pc_inc; // [RQ5]
    lpif.new_end     = lpif.load_single ? pc_inc : i_target; // [RQ9]
    lpif.new_count   = i_count_imm; // [RQ12]
    lpif.wr_start    = i_enable && i_wr_start;
    lpif.wr_end      = i_enable && i_wr_end;
    lpif.wr_count    = i_enable && i_wr_count; // [RQ5]
    lpif.wr_addr     = i_wr_addr;
    lpif.wr_cnt      = i_wr_cnt;
  end

  assign o_pc          = pc;
  assign o_loop_start  = lpif.start_addr;
  assign o_loop_end    = lpif.end_addr;
  assign o_loop_count  = lpif.count;
  assign o_loop_active = (lpif.mode != RPT_OFF);
  assign o_slot_busy   = in_slots;
endmodule

/* File: verification/dbrc_chk.sv */
// checker: port-level assertions for the flow sequencer
`timescale 1ns/10ps
module dbrc_chk (
  // clock and reset
  input wire logic                          i_clk,
  input wire logic                          i_reset_n,
  // request side
  input wire logic                          i_enable,
  input wire logic                          i_issue,
  input wire dbrc_pkg::dbrc_op_type         i_op,
  input wire logic [dbrc_pkg::COND_W-1:0]   i_cond,
  input wire logic [dbrc_pkg::ADDR_W-1:0]   i_target,
  input wire logic [dbrc_pkg::ADDR_W-1:0]   i_reg_value,
  input wire logic [dbrc_pkg::CNT_W-1:0]    i_count_imm,
  input wire logic                          i_int_req,
  input wire logic [dbrc_pkg::ADDR_W-1:0]   i_int_vec,
  // answer side
  input wire logic                          o_int_ack,
  input wire logic                          o_int_hold,
  input wire logic [dbrc_pkg::ADDR_W-1:0]   o_pc,
  input wire logic                          o_fetch_en,
  input wire logic                          o_reuse_instr,
  input wire logic                          o_push,
  input wire logic [dbrc_pkg::ADDR_W-1:0]   o_ret_addr,
  input wire logic [dbrc_pkg::ADDR_W-1:0]   o_loop_start,
  input wire logic [dbrc_pkg::ADDR_W-1:0]   o_loop_end,
  input wire logic [dbrc_pkg::CNT_W-1:0]    o_loop_count,
  input wire logic                          o_loop_active,
  input wire logic                          o_slot_busy
);
  import dbrc_pkg::*;
  logic tk;
  // an issue only counts when neither frozen nor displaced by an interrupt
  assign tk = i_enable && i_issue && !o_int_ack;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  a_slot_xfer: assert property (tk && i_op == OP_DBRANCH &&
    i_cond == COND_U && !o_slot_busy ##1 tk [*3]
    |=> !o_slot_busy && o_pc == $past(i_target, 4))
    else $error("delayed branch did not land after three slots");
  a_slot_noint: assert property (o_slot_busy |-> !o_int_ack)
    else $error("interrupt accepted inside delay slots");
  a_call_target: assert property (tk && i_op == OP_CALL_REG &&
    i_cond == COND_U && !o_slot_busy |=> o_pc == $past(i_reg_value)
    && o_push && o_ret_addr == $past(o_pc) + ADDR_ONE)
    else $error("register call went to wrong target");
  a_single_load: assert property (tk && i_op == OP_SINGLE_RPT &&
    !o_slot_busy |=> o_int_hold && o_loop_count == $past(i_count_imm)
    && o_loop_end == $past(o_pc) + ADDR_ONE)
    else $error("single repeat setup wrong");
  a_single_refetch: assert property (o_int_hold && tk &&
    o_pc == o_loop_end && o_loop_count != 32'h0
    |=> !o_fetch_en && o_reuse_instr)
    else $error("single repeat refetched its instruction");
  a_hold_noint: assert property (o_int_hold |-> !o_int_ack)
    else $error("interrupt accepted during single repeat");
  a_block_int: assert property (o_loop_active && !o_int_hold &&
    !o_slot_busy && i_enable && i_int_req |-> o_int_ack)
    else $error("interrupt refused during block repeat");
  a_loop_wrap: assert property (tk && o_loop_active && !o_slot_busy
    && o_pc == o_loop_end && o_loop_count != 32'h0
    |=> o_pc == $past(o_loop_start)
    && o_loop_count == $past(o_loop_count) - CNT_ONE)
    else $error("loop end did not wrap to start");
  a_loop_exit: assert property (tk && o_loop_active && !o_slot_busy
    && o_pc == o_loop_end && o_loop_count == 32'h0
    |=> !o_loop_active && o_pc == $past(o_pc) + ADDR_ONE)
    else $error("loop did not fall through after last pass");
  a_int_entry: assert property (o_int_ack |=> o_push &&
    o_pc == $past(i_int_vec) && o_ret_addr == $past(o_pc))
    else $error("interrupt entry wrong");
endmodule

bind delayed_branch_repeat_ctrl dbrc_chk chk_u (.i_clk, .i_reset_n,
  .i_enable, .i_issue, .i_op, .i_cond, .i_target, .i_reg_value,
  .i_count_imm, .i_int_req, .i_int_vec, .o_int_ack, .o_int_hold, .o_pc,
  .o_fetch_en, .o_reuse_instr, .o_push, .o_ret_addr, .o_loop_start,
  .o_loop_end, .o_loop_count, .o_loop_active, .o_slot_busy);

/* File: verification/delayed_branch_repeat_ctrl_tb.sv */
// testbench: directed checks of the flow sequencer
`timescale 1ns/10ps
module delayed_branch_repeat_ctrl_tb;
  import dbrc_pkg::*;
  typedef struct {
    dbrc_op_type       op;
    logic [COND_W-1:0] cond;
    logic [FLAG_W-1:0] flags;
    logic [ADDR_W-1:0] tgt;
    logic [ADDR_W-1:0] reg_v;
    logic              taken;
  } dbrc_row_type;
  logic              i_clk = 1'b0;
  logic              i_reset_n = 1'b0;
  logic              i_enable = 1'b1;
  logic              i_issue = 1'b0;
  dbrc_op_type       i_op = OP_NONE;
  logic [COND_W-1:0] i_cond = 4'h0;
  logic [FLAG_W-1:0] i_flags = 4'h0;
  logic [ADDR_W-1:0] i_target = 24'h0, i_reg_value = 24'h0;
  logic [ADDR_W-1:0] i_wr_addr = 24'h0, i_int_vec = 24'h300;
  logic [CNT_W-1:0]  i_count_imm = 32'h0, i_wr_cnt = 32'h0;
  logic              i_wr_start = 1'b0, i_wr_end = 1'b0;
  logic              i_wr_count = 1'b0, i_int_req = 1'b0;
  logic              o_int_ack, o_int_hold, o_fetch_en, o_reuse_instr;
  logic              o_push, o_loop_active, o_slot_busy;
  logic [ADDR_W-1:0] o_pc, o_ret_addr, o_loop_start, o_loop_end;
  logic [CNT_W-1:0]  o_loop_count;
  logic [ADDR_W-1:0] ep, nx;
  int                errors = 0, num_checks = 0, cyc = 0;
  // every condition code at least once; EQ and NE both taken and not taken
  dbrc_row_type rows[16] = '{
    '{OP_BRANCH, COND_U, 4'h0, 24'h100, 24'h0, 1'b1},
    '{OP_BRANCH, COND_EQ, 4'h4, 24'h200, 24'h0, 1'b1},
    '{OP_BRANCH, COND_EQ, 4'h0, 24'h2F0, 24'h0, 1'b0},
    '{OP_BRANCH, COND_NE, 4'h0, 24'h110, 24'h0, 1'b1},
    '{OP_BRANCH, COND_LT, 4'h8, 24'h120, 24'h0, 1'b1},
    '{OP_BRANCH, COND_GE, 4'h8, 24'h2F0, 24'h0, 1'b0},
    '{OP_BRANCH, COND_GT, 4'h0, 24'h130, 24'h0, 1'b1},
    '{OP_BRANCH, COND_LE, 4'h0, 24'h2F0, 24'h0, 1'b0},
    '{OP_BRANCH, COND_LO, 4'h1, 24'h140, 24'h0, 1'b1},
    '{OP_BRANCH, COND_HS, 4'h1, 24'h2F0, 24'h0, 1'b0},
    '{OP_BRANCH, COND_V, 4'h2, 24'h150, 24'h0, 1'b1},
    '{OP_BRANCH, COND_NV, 4'h2, 24'h2F0, 24'h0, 1'b0},
    '{OP_CALL, COND_U, 4'h0, 24'h500, 24'h0, 1'b1},
    '{OP_CALL_REG, COND_NE, 4'h4, 24'h2F0, 24'h600, 1'b0},
    '{OP_CALL_REG, COND_U, 4'h0, 24'h2F0, 24'h700, 1'b1},
    '{OP_RETURN, COND_U, 4'h0, 24'h050, 24'h0, 1'b1}};

  delayed_branch_repeat_ctrl dut_u (.i_clk, .i_reset_n, .i_enable,
    .i_issue, .i_op, .i_cond, .i_target, .i_reg_value, .i_count_imm,
    .i_flags, .i_wr_start, .i_wr_end, .i_wr_count, .i_wr_addr, .i_wr_cnt,
    .i_int_req, .i_int_vec, .o_int_ack, .o_int_hold, .o_pc, .o_fetch_en,
    .o_reuse_instr, .o_push, .o_ret_addr, .o_loop_start, .o_loop_end,
    .o_loop_count, .o_loop_active, .o_slot_busy);

  always #5 i_clk = ~i_clk;

  // whole run is about a hundred cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // request set at an edge, taken at the next one
  task automatic drive(dbrc_op_type op, logic [3:0] c, logic [3:0] f,
                       logic [23:0] t, logic [23:0] r);
    @(posedge i_clk);
    i_issue <= 1'b1;
    i_op <= op;
    i_cond <= c;
    i_flags <= f;
    i_target <= t;
    i_reg_value <= r;
    i_count_imm <= {8'h00, r};
  endtask

  task automatic idle();
    @(posedge i_clk);
    i_issue <= 1'b0;
    i_op <= OP_NONE;
    #1;
  endtask

  task automatic nones(int n, logic [3:0] f);
    repeat (n) drive(OP_NONE, COND_U, f, 24'h0, 24'h0);
  endtask

  // slot flags differ from the branch's to catch late sampling
  task automatic dbr(logic [3:0] c, logic [3:0] f, logic [3:0] sf,
                     logic tk);
    drive(OP_DBRANCH, c, f, 24'h080, 24'h0);
    nones(1, sf);
    #1;
    check("db_busy", o_slot_busy, 1'b1);
    nones(2, sf);
    idle();
    check("db_idle", o_slot_busy, 1'b0);
    ep = tk ? 24'h080 : ep + 24'h4;
    check("db_pc", o_pc, ep);
  endtask

  task automatic rstchk();
    check("pc_rst", o_pc, RESET_PC);
    check("cnt_rst", o_loop_count, RESET_COUNT);
    check("act_rst", o_loop_active, 1'b0);
    check("fetch_rst", o_fetch_en, 1'b1);
    check("push_rst", o_push, 1'b0);
    check("slot_rst", o_slot_busy, 1'b0);
    check("hold_rst", o_int_hold, 1'b0);
  endtask

  initial begin
    repeat (15) @(posedge i_clk);
    #1;
    rstchk();
    @(posedge i_clk);
    i_reset_n <= 1'b1;
    ep = RESET_PC;
    foreach (rows[k]) begin
      drive(rows[k].op, rows[k].cond, rows[k].flags, rows[k].tgt,
            rows[k].reg_v);
      idle();
      nx = rows[k].op == OP_CALL_REG ? rows[k].reg_v : rows[k].tgt;
      check("push", o_push, rows[k].taken && rows[k].op != OP_BRANCH &&
            rows[k].op != OP_RETURN);
      if (rows[k].taken && (rows[k].op == OP_CALL ||
          rows[k].op == OP_CALL_REG))
        check("ret", o_ret_addr, ep + 24'h1);
      ep = rows[k].taken ? nx : ep + 24'h1;
      check("pc", o_pc, ep);
    end
    dbr(COND_U, 4'h0, 4'h0, 1'b1);
    dbr(COND_EQ, 4'h4, 4'h0, 1'b1);
    dbr(COND_EQ, 4'h0, 4'h4, 1'b0);
    // software load of all loop registers; start and count read back for saving
    @(posedge i_clk);
    {i_wr_start, i_wr_end, i_wr_count} <= 3'h7;
    i_wr_addr <= 24'h5A5;
    i_wr_cnt <= 32'h2;
    @(posedge i_clk);
    {i_wr_start, i_wr_end, i_wr_count} <= 3'h0;
    #1;
    check("sw_start", o_loop_start, 24'h5A5);
    check("sw_cnt", o_loop_count, 32'h2);
    drive(OP_BLOCK_RPT, COND_U, 4'h0, ep + 24'h2, 24'h0);
    idle();
    check("blk_start", o_loop_start, ep + 24'h1);
    check("blk_end", o_loop_end, ep + 24'h2);
    nones(3, 4'h0);
    idle();
    check("blk_pc", o_pc, ep + 24'h2);
    check("blk_cnt", o_loop_count, 32'h1);
    @(posedge i_clk);
    i_int_req <= 1'b1;
    #1;
    check("blk_ack", o_int_ack, 1'b1);
    @(posedge i_clk);
    i_int_req <= 1'b0;
    #1;
    check("isr_pc", o_pc, 24'h300);
    drive(OP_RETURN, COND_U, 4'h0, ep + 24'h2, 24'h0);
    nones(2, 4'h0);
    idle();
    check("blk_act", o_loop_active, 1'b1);
    nones(1, 4'h0);
    idle();
    ep = ep + 24'h3;
    check("blk_exit", o_pc, ep);
    check("blk_done", o_loop_active, 1'b0);
    check("blk_cntx", o_loop_count, 32'hFFFFFFFF);
    // frozen core ignores the issue
    @(posedge i_clk);
    i_enable <= 1'b0;
    drive(OP_BRANCH, COND_U, 4'h0, 24'h123, 24'h0);
    @(posedge i_clk);
    i_issue <= 1'b0;
    i_op <= OP_NONE;
    i_enable <= 1'b1;
    #1;
    check("frz_pc", o_pc, ep);
    drive(OP_SINGLE_RPT, COND_U, 4'h0, 24'h0, 24'h2);
    idle();
    check("one_hold", o_int_hold, 1'b1);
    check("one_cnt", o_loop_count, 32'h2);
    check("one_start", o_loop_start, ep + 24'h1);
    nones(1, 4'h0);
    idle();
    check("one_pc", o_pc, ep + 24'h1);
    check("one_fetch", o_fetch_en, 1'b0);
    check("one_reuse", o_reuse_instr, 1'b1);
    @(posedge i_clk);
    i_int_req <= 1'b1;
    #1;
    check("one_ack", o_int_ack, 1'b0);
    nones(1, 4'h0);
    i_int_req <= 1'b0;
    nones(1, 4'h0);
    idle();
    check("one_exit", o_pc, ep + 24'h2);
    idle();
    check("one_refetch", o_fetch_en, 1'b1);
    check("one_reuse0", o_reuse_instr, 1'b0);
    check("one_free", o_int_hold, 1'b0);
    // reset again in mid-run, inside delay slots
    drive(OP_DBRANCH, COND_U, 4'h0, 24'h080, 24'h0);
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    i_issue <= 1'b0;
    #1;
    rstchk();
    @(posedge i_clk);
    i_reset_n <= 1'b1;
    // stale slots would make this branch be ignored
    drive(OP_BRANCH, COND_U, 4'h0, 24'h0AB, 24'h0);
    idle();
    check("rst_br", o_pc, 24'h0AB);
    test_done();
  end
endmodule
